/* File: common/dtc_map.svh */
/*
  Register offsets, field positions, reset values and timing counts
  of the dual timer/counter block.
  Assumes inclusion by its bare name from the design files.
*/
`ifndef DTC_MAP_SVH
`define DTC_MAP_SVH

// Register word offsets on the plain register port
`define DTC_OFF_MODE   4'h0
`define DTC_OFF_CTRL   4'h1
`define DTC_OFF_CNT0H  4'h2
`define DTC_OFF_CNT0L  4'h3
`define DTC_OFF_CNT1H  4'h4
`define DTC_OFF_CNT1L  4'h5
`define DTC_OFF_ISTAT  4'h6
`define DTC_OFF_IMASK  4'h7

// Mode register nibbles
`define DTC_MODE_U0    3:0
`define DTC_MODE_U1    7:4

// Control register fields
`define DTC_TC_IT0     0
`define DTC_TC_IE0     1
`define DTC_TC_IT1     2
`define DTC_TC_IE1     3
`define DTC_TC_TR0     4
`define DTC_TC_TF0     5
`define DTC_TC_TR1     6
`define DTC_TC_TF1     7

// Interrupt status / mask fields
`define DTC_IS_TF0     0
`define DTC_IS_TF1     1
`define DTC_IS_IE0     2
`define DTC_IS_IE1     3
`define DTC_IS_W       4

// Reset values
`define DTC_RST_BYTE   8'h00
`define DTC_RST_IRQ    4'h0

// Oscillator periods per machine cycle
`define DTC_MCYCLE_CLKS 12

`endif

/* File: common/dtc_pkg.sv */
/*
  Types shared by the dual timer/counter block.
  Assumes dtc_map.svh supplies the numeric constants.
*/
package dtc_pkg;

  typedef enum logic [1:0] {
    DTC_M13    = 2'h0,
    DTC_M16    = 2'h1,
    DTC_M8R    = 2'h2,
    DTC_MSPLIT = 2'h3
  } dtc_mode_e;

  typedef struct packed {
    logic       gate;
    logic       ext_src;
    dtc_mode_e  mode;
  } dtc_unit_cfg_s;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } dtc_bus_s;

  typedef struct packed {
    logic       ovf;
    logic [7:0] hi;
    logic [7:0] lo;
  } dtc_cnt_s;

endpackage

/* File: core/dtc_top.sv */
/*
  Dual 16-bit timer/counter with mode, run/flag and count registers,
  external count and gate pins, and a masked interrupt output.
  Assumes core_clk is the oscillator, pins are asynchronous, and the
  register master follows the one-cycle strobe protocol.
*/
`timescale 1ns/1ps
`include "dtc_map.svh"

module dtc_top
  import dtc_pkg::*;
#(
  parameter int CLKS_PER_MCYCLE = `DTC_MCYCLE_CLKS
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  // Register port
  input  wire dtc_pkg::dtc_bus_s bus_req,
  output logic [7:0]            rd_data,
  // External pins
  input  wire logic             count_input0_pin,
  input  wire logic             count_input1_pin,
  input  wire logic             ext_irq0_pin,
  input  wire logic             ext_irq1_pin,
  // Interrupt processed strobes
  input  wire logic             irq_ack0,
  input  wire logic             irq_ack1,
  // Status
  output logic                  irq_out,
  output logic                  unit0_overflow_flag,
  output logic                  unit1_overflow_flag,
  output logic                  ext_irq0_edge_flag,
  output logic                  ext_irq1_edge_flag
);
  import dtc_pkg::*;

  localparam logic [3:0] PRESC_LAST = 4'(CLKS_PER_MCYCLE - 1);

  logic [7:0]         mode_reg;
  logic [7:0]         ctrl_reg;
  logic [7:0]         ctrl_next;
  logic [7:0]         cnt0h_reg;
  logic [7:0]         cnt0h_next;
  logic [7:0]         cnt0l_reg;
  logic [7:0]         cnt0l_next;
  logic [7:0]         cnt1h_reg;
  logic [7:0]         cnt1h_next;
  logic [7:0]         cnt1l_reg;
  logic [7:0]         cnt1l_next;
  logic [`DTC_IS_W-1:0] istat_reg;
  logic [`DTC_IS_W-1:0] istat_next;
  logic [`DTC_IS_W-1:0] imask_reg;
  logic [7:0]         rd_data_reg;
  logic [7:0]         rd_next;
  logic               irq_reg;
  logic [3:0]         presc_reg;
  logic [3:0]         sync1_reg;
  logic [3:0]         sync2_reg;
  logic [1:0]         samp_reg;
  logic [1:0]         prev_reg;
  logic [1:0]         irq_prev_reg;

  // Register decode
  wire wr_mode  = bus_req.wr && bus_req.addr == `DTC_OFF_MODE;
  wire wr_ctrl  = bus_req.wr && bus_req.addr == `DTC_OFF_CTRL;
  wire wr_c0h   = bus_req.wr && bus_req.addr == `DTC_OFF_CNT0H;
  wire wr_c0l   = bus_req.wr && bus_req.addr == `DTC_OFF_CNT0L;
  wire wr_c1h   = bus_req.wr && bus_req.addr == `DTC_OFF_CNT1H;
  wire wr_c1l   = bus_req.wr && bus_req.addr == `DTC_OFF_CNT1L;
  wire wr_istat = bus_req.wr && bus_req.addr == `DTC_OFF_ISTAT;
  wire wr_imask = bus_req.wr && bus_req.addr == `DTC_OFF_IMASK;

  // Per-unit configuration nibbles
  wire dtc_unit_cfg_s cfg0 = dtc_unit_cfg_s'(mode_reg[`DTC_MODE_U0]);
  wire dtc_unit_cfg_s cfg1 = dtc_unit_cfg_s'(mode_reg[`DTC_MODE_U1]);

  // Machine-cycle tick
  wire tick = presc_reg == PRESC_LAST;

  // Pins: count1, count0, irq1, irq0
  wire [3:0] pins_raw = {count_input1_pin, count_input0_pin,
                         ext_irq1_pin, ext_irq0_pin};
  wire [1:0] irq_s = sync2_reg[1:0];
  wire [1:0] cnt_s = sync2_reg[3:2];

  logic [1:0] cnt_ev;
  logic [1:0] irq_fall;
  logic [1:0] ie_next;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          sync1_reg[gi] <= 1'b1;
          sync2_reg[gi] <= 1'b1;
        end else begin
          sync1_reg[gi] <= pins_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
    for (gi = 0; gi < 2; gi++) begin : g_chan
      // Sampled once per machine cycle, compared one cycle later
      assign cnt_ev[gi]   = tick && prev_reg[gi] && !samp_reg[gi];
      assign irq_fall[gi] = irq_prev_reg[gi] && !irq_s[gi];
      // Level mode mirrors the pin; edge mode latches until processed
      assign ie_next[gi] =
        !ctrl_reg[2*gi] ? !irq_s[gi] :
        irq_fall[gi] ||
        (!(gi == 0 ? irq_ack0 : irq_ack1) &&
         (wr_ctrl ? bus_req.wdata[2*gi+1] : ctrl_reg[2*gi+1]));
    end
  endgenerate

  // One step of a unit in modes 0..2; mode 3 holds
  function automatic dtc_cnt_s cnt_step(input dtc_mode_e m,
                                        input logic [7:0] hi,
                                        input logic [7:0] lo,
                                        input logic en);
    dtc_cnt_s   r;
    logic [8:0] lo_s;
    logic [8:0] hi_s;
    logic [5:0] p_s;
    r    = '{ovf: 1'b0, hi: hi, lo: lo};
    lo_s = {1'b0, lo} + 9'h001;
    hi_s = {1'b0, hi} + 9'h001;
    p_s  = {1'b0, lo[4:0]} + 6'h01;
    if (en) begin
      case (m)
        DTC_M13: begin
          // Upper three low-byte bits are left alone
          r.lo = {lo[7:5], p_s[4:0]};
          if (p_s[5]) begin
            r.hi  = hi_s[7:0];
            r.ovf = hi_s[8];
          end
        end
        DTC_M16: begin
          r.lo = lo_s[7:0];
          if (lo_s[8]) begin
            r.hi  = hi_s[7:0];
            r.ovf = hi_s[8];
          end
        end
        DTC_M8R: begin
          r.lo  = lo_s[8] ? hi : lo_s[7:0];
          r.ovf = lo_s[8];
        end
        default: r.ovf = 1'b0;
      endcase
    end
    return r;
  endfunction

  // Run qualification
  wire run0 = ctrl_reg[`DTC_TC_TR0] &&
              (!cfg0.gate || irq_s[0]);
  wire run1 = ctrl_reg[`DTC_TC_TR1] &&
              (!cfg1.gate || irq_s[1]);
  wire ev0  = cfg0.ext_src ? cnt_ev[0] : tick;
  wire ev1  = cfg1.ext_src ? cnt_ev[1] : tick;
  wire en0  = ev0 && run0;
  wire en1  = ev1 && run1;

  wire dtc_cnt_s step0 = cnt_step(cfg0.mode, cnt0h_reg, cnt0l_reg, en0);
  wire dtc_cnt_s step1 = cnt_step(cfg1.mode, cnt1h_reg, cnt1l_reg, en1);

  // Split mode of unit 0
  wire       split   = cfg0.mode == DTC_MSPLIT;
  wire       hi0_en  = tick && ctrl_reg[`DTC_TC_TR1];
  wire [8:0] lo0_inc = {1'b0, cnt0l_reg} + 9'h001;
  wire [8:0] hi0_inc = {1'b0, cnt0h_reg} + 9'h001;
  wire [7:0] u0_lo   = !split ? step0.lo :
                       en0 ? lo0_inc[7:0] : cnt0l_reg;
  wire [7:0] u0_hi   = !split ? step0.hi :
                       hi0_en ? hi0_inc[7:0] : cnt0h_reg;
  wire tf0_set = split ? en0 && lo0_inc[8] : step0.ovf;
  wire tf1_set = split ? hi0_en && hi0_inc[8] : step1.ovf;

  // CPU byte writes take precedence over counting
  assign cnt0h_next = wr_c0h ? bus_req.wdata : u0_hi;
  assign cnt0l_next = wr_c0l ? bus_req.wdata : u0_lo;
  assign cnt1h_next = wr_c1h ? bus_req.wdata : step1.hi;
  assign cnt1l_next = wr_c1l ? bus_req.wdata : step1.lo;

  // Control register: hardware set beats software clear
  wire tf0_n = tf0_set ||
               (wr_ctrl ? bus_req.wdata[`DTC_TC_TF0]
                        : ctrl_reg[`DTC_TC_TF0]);
  wire tf1_n = tf1_set ||
               (wr_ctrl ? bus_req.wdata[`DTC_TC_TF1]
                        : ctrl_reg[`DTC_TC_TF1]);
  wire [3:0] ctl_sw = wr_ctrl ?
    {bus_req.wdata[`DTC_TC_TR1], bus_req.wdata[`DTC_TC_TR0],
     bus_req.wdata[`DTC_TC_IT1], bus_req.wdata[`DTC_TC_IT0]} :
    {ctrl_reg[`DTC_TC_TR1], ctrl_reg[`DTC_TC_TR0],
     ctrl_reg[`DTC_TC_IT1], ctrl_reg[`DTC_TC_IT0]};
  assign ctrl_next = {tf1_n, ctl_sw[3], tf0_n, ctl_sw[2],
                      ie_next[1], ctl_sw[1], ie_next[0], ctl_sw[0]};

  // Sticky interrupt status, write one to clear
  wire [`DTC_IS_W-1:0] ev_vec = {irq_fall[1], irq_fall[0],
                                 tf1_set, tf0_set};
  wire [`DTC_IS_W-1:0] clr_vec = wr_istat ?
                                 bus_req.wdata[`DTC_IS_W-1:0] :
                                 `DTC_RST_IRQ;
  assign istat_next = ev_vec | (istat_reg & ~clr_vec);

  // Read mux; unmapped offsets read as zero
  assign rd_next =
    bus_req.addr == `DTC_OFF_MODE  ? mode_reg  :
    bus_req.addr == `DTC_OFF_CTRL  ? ctrl_reg  :
    bus_req.addr == `DTC_OFF_CNT0H ? cnt0h_reg :
    bus_req.addr == `DTC_OFF_CNT0L ? cnt0l_reg :
    bus_req.addr == `DTC_OFF_CNT1H ? cnt1h_reg :
    bus_req.addr == `DTC_OFF_CNT1L ? cnt1l_reg :
    bus_req.addr == `DTC_OFF_ISTAT ? {4'h0, istat_reg} :
    bus_req.addr == `DTC_OFF_IMASK ? {4'h0, imask_reg} : `DTC_RST_BYTE;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      presc_reg    <= 4'h0;
      samp_reg     <= 2'h3;
      prev_reg     <= 2'h3;
      irq_prev_reg <= 2'h3;
    end else begin
      presc_reg    <= tick ? 4'h0 : presc_reg + 4'h1;
      irq_prev_reg <= irq_s;
      if (tick) begin
        samp_reg <= cnt_s;
        prev_reg <= samp_reg;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_reg  <= `DTC_RST_BYTE;
      ctrl_reg  <= `DTC_RST_BYTE;
      cnt0h_reg <= `DTC_RST_BYTE;
      cnt0l_reg <= `DTC_RST_BYTE;
      cnt1h_reg <= `DTC_RST_BYTE;
      cnt1l_reg <= `DTC_RST_BYTE;
    end else begin
      if (wr_mode) begin
        mode_reg <= bus_req.wdata;
      end
      ctrl_reg  <= ctrl_next;
      cnt0h_reg <= cnt0h_next;
      cnt0l_reg <= cnt0l_next;
      cnt1h_reg <= cnt1h_next;
      cnt1l_reg <= cnt1l_next;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      istat_reg   <= `DTC_RST_IRQ;
      imask_reg   <= `DTC_RST_IRQ;
      irq_reg     <= 1'b0;
      rd_data_reg <= `DTC_RST_BYTE;
    end else begin
      istat_reg   <= istat_next;
      irq_reg     <= |(istat_next & imask_reg);
      rd_data_reg <= bus_req.rd ? rd_next : `DTC_RST_BYTE;
      if (wr_imask) begin
        imask_reg <= bus_req.wdata[`DTC_IS_W-1:0];
      end
    end
  end

  assign rd_data             = rd_data_reg;
  assign irq_out             = irq_reg;
  assign unit0_overflow_flag = ctrl_reg[`DTC_TC_TF0];
  assign unit1_overflow_flag = ctrl_reg[`DTC_TC_TF1];
  assign ext_irq0_edge_flag  = ctrl_reg[`DTC_TC_IE0];
  assign ext_irq1_edge_flag  = ctrl_reg[`DTC_TC_IE1];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  wire no_cnt_wr = !(wr_c0h || wr_c0l || wr_c1h || wr_c1l);

  sequence s_irq0_fall;
    irq_prev_reg[0] && !irq_s[0];
  endsequence

  sequence s_cnt0_fall;
    tick && samp_reg[0] ##1 !samp_reg[0] && prev_reg[0];
  endsequence

  a_tick_period: assert property (tick |-> ##12 tick)
    else $error("machine cycle tick not every twelve clocks");

  a_run_stop: assert property (
    !ctrl_reg[`DTC_TC_TR0] && !wr_c0l |=> $stable(cnt0l_reg))
    else $error("unit 0 low byte moved with run clear");

  a_gate_block: assert property (
    cfg0.gate && !irq_s[0] && !wr_c0l |=> $stable(cnt0l_reg))
    else $error("gated unit 0 moved with irq pin low");

  a_split_hold: assert property (
    cfg1.mode == DTC_MSPLIT && !wr_c1h && !wr_c1l
    |=> $stable(cnt1l_reg) && $stable(cnt1h_reg))
    else $error("unit 1 moved in hold mode");

  a_timer_step: assert property (
    cfg0.mode == DTC_M16 && !cfg0.ext_src && run0 && tick &&
    cnt0l_reg != 8'hFF && no_cnt_wr
    |=> cnt0l_reg == $past(cnt0l_reg) + 8'h01)
    else $error("timer low byte did not step on tick");

  // Split unit 0 takes flag 1 away from unit 1
  a_reload_ovf: assert property (
    cfg1.mode == DTC_M8R && !split && en1 && cnt1l_reg == 8'hFF &&
    no_cnt_wr
    |=> cnt1l_reg == cnt1h_reg && ctrl_reg[`DTC_TC_TF1])
    else $error("mode 2 reload or flag missing");

  a_ovf_flag: assert property (tf1_set |=> unit1_overflow_flag)
    else $error("overflow flag not set after overflow");

  a_edge_flag: assert property (
    (ctrl_reg[`DTC_TC_IT0] && !wr_ctrl) and s_irq0_fall
    |=> ext_irq0_edge_flag)
    else $error("edge flag not set on irq0 falling edge");

  a_cnt_event: assert property (
    s_cnt0_fall ##11 (tick && cfg0.ext_src && run0 &&
    cfg0.mode == DTC_M16 && no_cnt_wr && cnt0l_reg != 8'hFF)
    |=> cnt0l_reg == $past(cnt0l_reg) + 8'h01)
    else $error("counter missed recognised falling edge");

  a_irq_level: assert property (
    |(istat_next & imask_reg) |=> irq_out)
    else $error("interrupt output low with unmasked status");

endmodule

/* File: dv/dtc_pin_model.sv */
/*
  Far-side model of the count and gate/interrupt pins.
  Assumes the bench calls its tasks right after a rising core_clk edge.
*/
`timescale 1ns/1ps
module dtc_pin_model (
  // Clock
  input  wire logic core_clk,
  // Pins toward the block, pulled up when idle
  output logic      count_input0_pin,
  output logic      count_input1_pin,
  output logic      ext_irq0_pin,
  output logic      ext_irq1_pin
);
  initial begin
    count_input0_pin = 1'b1;
    count_input1_pin = 1'b1;
    ext_irq0_pin     = 1'b1;
    ext_irq1_pin     = 1'b1;
  end

  // Each level held two machine cycles so both samples see it
  task automatic pulse_count(input int unsigned idx, input int unsigned n);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      if (idx == 0) count_input0_pin <= 1'b0;
      else count_input1_pin <= 1'b0;
      repeat (24) @(posedge core_clk);
      if (idx == 0) count_input0_pin <= 1'b1;
      else count_input1_pin <= 1'b1;
      repeat (23) @(posedge core_clk);
    end
  endtask

  task automatic set_irq_pin(input int unsigned idx, input logic v);
    @(posedge core_clk);
    if (idx == 0) ext_irq0_pin <= v;
    else ext_irq1_pin <= v;
  endtask
endmodule

/* File: dv/testbench.sv */
/*
  Self-checking bench for the dual timer/counter block.
  Assumes the pin model stands for the far side and the bench is the CPU.
*/
`timescale 1ns/1ps
`include "dtc_map.svh"
module testbench;
  import dtc_pkg::*;
  logic       core_clk;
  logic       sys_rst;
  dtc_bus_s   bus_req;
  logic [7:0] rd_data;
  logic       cnt_pin0;
  logic       cnt_pin1;
  logic       irq_pin0;
  logic       irq_pin1;
  logic       irq_ack0;
  logic       irq_ack1;
  logic       irq_out;
  logic       ovf0;
  logic       ovf1;
  logic       edg0;
  logic       edg1;
  logic [1:0] ovf_seen;
  int         n_mismatch = 0;
  int         n_compared = 0;
  int         cycles     = 0;

  dtc_top dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .bus_req(bus_req),
    .rd_data(rd_data), .count_input0_pin(cnt_pin0),
    .count_input1_pin(cnt_pin1), .ext_irq0_pin(irq_pin0),
    .ext_irq1_pin(irq_pin1), .irq_ack0(irq_ack0), .irq_ack1(irq_ack1),
    .irq_out(irq_out), .unit0_overflow_flag(ovf0),
    .unit1_overflow_flag(ovf1), .ext_irq0_edge_flag(edg0),
    .ext_irq1_edge_flag(edg1)
  );

  dtc_pin_model pins (
    .core_clk(core_clk), .count_input0_pin(cnt_pin0),
    .count_input1_pin(cnt_pin1), .ext_irq0_pin(irq_pin0),
    .ext_irq1_pin(irq_pin1)
  );

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic conclude();
    if (n_mismatch == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Whole run needs about 1000 cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1 chk(rd_data, exp);
  endtask

  // Run bit high for exactly 12*k clocks, so k ticks whatever the phase
  task automatic run(input logic [7:0] ctl, input int unsigned k);
    wr(`DTC_OFF_CTRL, ctl);
    repeat (12 * k - 2) @(posedge core_clk);
    #1 ovf_seen = {ovf1, ovf0};
    wr(`DTC_OFF_CTRL, 8'h00);
  endtask

  task automatic expect_run(input logic [1:0] ovf, input logic [3:0] a,
                            input logic [15:0] cnt, input logic [7:0] st);
    #1 chk({6'h00, ovf1, ovf0}, 8'h00);
    chk({6'h00, ovf_seen}, {6'h00, ovf});
    rchk(a, cnt[15:8]);
    rchk(a + 4'h1, cnt[7:0]);
    rchk(`DTC_OFF_ISTAT, st);
    wr(`DTC_OFF_ISTAT, 8'h0F);
  endtask

  initial begin
    sys_rst  = 1'b1;
    bus_req  = '0;
    irq_ack0 = 1'b0;
    irq_ack1 = 1'b0;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    wr(4'h8, 8'hFF);
    for (int a = 0; a < 9; a++) rchk(a[3:0], 8'h00);
    for (int a = 2; a < 6; a++) wr(a[3:0], 8'(8'h11 * a));
    for (int a = 2; a < 6; a++) rchk(a[3:0], 8'(8'h11 * a));
    wr(`DTC_OFF_MODE, 8'hC6);
    rchk(`DTC_OFF_MODE, 8'hC6);
    wr(`DTC_OFF_CTRL, 8'h05);
    rchk(`DTC_OFF_CTRL, 8'h05);
    // 16-bit timer wraps on the second of three ticks, pin low ignored
    wr(`DTC_OFF_CNT0H, 8'hFF);
    wr(`DTC_OFF_CNT0L, 8'hFE);
    wr(`DTC_OFF_MODE, 8'h01);
    wr(`DTC_OFF_IMASK, 8'h00);
    pins.set_irq_pin(0, 1'b0);
    run(8'h10, 3);
    #1 chk({7'h00, irq_out}, 8'h00);
    wr(`DTC_OFF_IMASK, 8'h01);
    repeat (2) @(posedge core_clk);
    #1 chk({7'h00, irq_out}, 8'h01);
    expect_run(2'b01, `DTC_OFF_CNT0H, 16'h0001, 8'h05);
    repeat (2) @(posedge core_clk);
    #1 chk({7'h00, irq_out}, 8'h00);
    pins.set_irq_pin(0, 1'b1);
    // 13-bit: prescaler carries into high byte, low top bits kept
    wr(`DTC_OFF_CNT0H, 8'hFF);
    wr(`DTC_OFF_CNT0L, 8'hFE);
    wr(`DTC_OFF_MODE, 8'h00);
    run(8'h10, 3);
    expect_run(2'b01, `DTC_OFF_CNT0H, 16'h00E1, 8'h01);
    wr(`DTC_OFF_CNT1H, 8'h80);
    wr(`DTC_OFF_CNT1L, 8'hFE);
    wr(`DTC_OFF_MODE, 8'h20);
    run(8'h40, 3);
    expect_run(2'b10, `DTC_OFF_CNT1H, 16'h8081, 8'h02);
    wr(`DTC_OFF_CNT0H, 8'hFE);
    wr(`DTC_OFF_CNT0L, 8'hFE);
    wr(`DTC_OFF_MODE, 8'h33);
    run(8'h50, 3);
    expect_run(2'b11, `DTC_OFF_CNT0H, 16'h0101, 8'h03);
    rchk(`DTC_OFF_CNT1L, 8'h81);
    // Gated timer
    wr(`DTC_OFF_CNT0L, 8'h00);
    wr(`DTC_OFF_MODE, 8'h09);
    pins.set_irq_pin(0, 1'b0);
    repeat (4) @(posedge core_clk);
    run(8'h10, 3);
    rchk(`DTC_OFF_CNT0L, 8'h00);
    pins.set_irq_pin(0, 1'b1);
    repeat (4) @(posedge core_clk);
    run(8'h10, 3);
    rchk(`DTC_OFF_CNT0L, 8'h03);
    for (int i = 0; i < 2; i++) begin
      wr(i ? `DTC_OFF_CNT1L : `DTC_OFF_CNT0L, 8'h00);
      wr(`DTC_OFF_MODE, i ? 8'h50 : 8'h05);
      wr(`DTC_OFF_CTRL, i ? 8'h40 : 8'h10);
      pins.pulse_count(i, 5);
      repeat (24) @(posedge core_clk);
      wr(`DTC_OFF_CTRL, 8'h00);
      rchk(i ? `DTC_OFF_CNT1L : `DTC_OFF_CNT0L, 8'h05);
    end
    for (int i = 0; i < 2; i++) begin
      wr(`DTC_OFF_CTRL, i ? 8'h04 : 8'h01);
      pins.set_irq_pin(i, 1'b0);
      repeat (6) @(posedge core_clk);
      #1 chk({6'h00, edg1, edg0}, i ? 8'h02 : 8'h01);
      @(posedge core_clk);
      {irq_ack1, irq_ack0} <= i ? 2'b10 : 2'b01;
      @(posedge core_clk);
      {irq_ack1, irq_ack0} <= 2'b00;
      repeat (2) @(posedge core_clk);
      #1 chk({6'h00, edg1, edg0}, 8'h00);
      pins.set_irq_pin(i, 1'b1);
    end
    // Level type follows the pin
    wr(`DTC_OFF_CTRL, 8'h00);
    pins.set_irq_pin(1, 1'b0);
    repeat (6) @(posedge core_clk);
    #1 chk({6'h00, edg1, edg0}, 8'h02);
    pins.set_irq_pin(1, 1'b1);
    repeat (6) @(posedge core_clk);
    #1 chk({6'h00, edg1, edg0}, 8'h00);
    rchk(`DTC_OFF_ISTAT, 8'h0C);
    wr(`DTC_OFF_ISTAT, 8'h0F);
    rchk(`DTC_OFF_ISTAT, 8'h00);
    conclude();
  end
endmodule
